/* bench/rpic_host_model.sv */
/*
 * Host model that issues register reads and writes as one-cycle strobes.
 * Assumes the block takes a strobe at a rising edge and registers read data
 * at that same edge.
 */
`timescale 1ns/1ps
module rpic_host_model
(
    input  wire logic       clk_sys_i,   // System clock.
    input  wire logic [7:0] reg_rdata_i, // Read data from the block.
    output logic      [7:0] reg_addr_o,  // Register address.
    output logic            reg_wr_o,    // Write strobe.
    output logic            reg_rd_o,    // Read strobe.
    output logic      [7:0] reg_wdata_o  // Write data.
);
    // The bus is idle at time zero.
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    // Hold one rising edge, then scramble the idle bus so stale values fail.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys_i);
        reg_addr_o  = addr;
        reg_wdata_o = data;
        reg_wr_o    = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~addr;
        reg_wdata_o = ~data;
    endtask
    // Read data is registered at the edge that takes the strobe.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys_i);
        reg_addr_o = addr;
        reg_rd_o   = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o   = 1'b0;
        reg_addr_o = ~addr;
        data       = reg_rdata_i;
    endtask
endmodule

/* bench/tb_top.sv */
/*
 * Self-checking bench for the receive-port interrupt block.
 * Assumes the host model for register access and four receive ports.
 */
`timescale 1ns/1ps
module tb_top;
    import rpic_pkg::*;
    typedef struct { int ev; logic [7:0] addr; logic [7:0] val; logic sec; }
        rpic_row_type;
    logic        clk_sys_i, sys_rst_i, sts_first_rd_i, sts_second_rd_i;
    logic        reg_wr, reg_rd, irq_o;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd, hi, lo;
    logic [3:0]  ev [9];
    logic [31:0] st_low_o;
    int          n_mismatch, checks;
    rpic_row_type rows [9] = '{'{0, 8'hd8, 8'h04, 1}, '{1, 8'hd8, 8'h02, 0},
        '{2, 8'hd8, 8'h01, 0}, '{3, 8'hd9, 8'h40, 1}, '{4, 8'hd9, 8'h20, 1},
        '{5, 8'hd9, 8'h10, 1}, '{6, 8'hd9, 8'h04, 0}, '{7, 8'hd9, 8'h02, 0},
        '{8, 8'hd9, 8'h01, 0}};
    rpic_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata),
        .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_wdata_o(reg_wdata));
    rpic_top #(.NPORTS(4)) uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .sts_first_rd_i(sts_first_rd_i), .sts_second_rd_i(sts_second_rd_i),
        .encode_fault_i(ev[0]), .order_fault_i(ev[1]), .check_fault_i(ev[2]),
        .line_length_i(ev[3]), .line_total_i(ev[4]), .rx_overflow_i(ev[5]),
        .link_parity_i(ev[6]), .port_valid_i(ev[7]), .lock_change_i(ev[8]),
        .st_low_o(st_low_o), .irq_o(irq_o));
    // Free-running 100 MHz clock.
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Compares one byte and reports a difference at once.
    task automatic check8(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    // One-cycle event pulse on a port, optionally with status-read clears.
    task automatic pulse(input int idx, input int port, input logic c1,
                         input logic c2);
        @(negedge clk_sys_i);
        if (idx >= 0)
            ev[idx][port] = 1'b1;
        sts_first_rd_i  = c1;
        sts_second_rd_i = c2;
        @(negedge clk_sys_i);
        if (idx >= 0)
            ev[idx][port] = 1'b0;
        sts_first_rd_i  = 1'b0;
        sts_second_rd_i = 1'b0;
    endtask
    // High status of the read port, low status of a port, and the request.
    task automatic check_state(input logic [7:0] hi, input logic [7:0] lo,
                               input logic irq, input int port);
        host.read_reg(ADDR_ST_HIGH, rd);
        check8("status high", hi, rd);
        check8("status low", lo, st_low_o[port*8 +: 8]);
        check8("irq", {7'h00, irq}, {7'h00, irq_o});
    endtask
    // Reads a register and compares it.
    task automatic check_reg(input logic [7:0] addr, input logic [7:0] exp);
        host.read_reg(addr, rd);
        check8("register", exp, rd);
    endtask
    // Watchdog: a hang counts as a mismatch.
    initial
    begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    // Main sequence.
    initial
    begin
        sys_rst_i       = 1'b1;
        sts_first_rd_i  = 1'b0;
        sts_second_rd_i = 1'b0;
        foreach (ev[i])
            ev[i] = 4'h0;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        check8("irq after reset", 8'h00, {7'h00, irq_o});
        check8("low after reset", 8'h00, st_low_o[7:0]);
        check_reg(ADDR_EN_HIGH, REG_RESET);
        check_reg(ADDR_EN_LOW, REG_RESET);
        check_reg(ADDR_ST_HIGH, REG_RESET);
        check_reg(ADDR_PORT_SEL, SEL_RESET);
        $display("test reset done");
        foreach (rows[i])
        begin
            hi = rows[i].addr == ADDR_EN_HIGH ? rows[i].val : 8'h00;
            lo = rows[i].addr == ADDR_EN_LOW ? rows[i].val : 8'h00;
            host.write_reg(ADDR_EN_HIGH, hi);
            host.write_reg(ADDR_EN_LOW, lo);
            pulse(rows[i].ev, 0, 1'b0, 1'b0);
            check_state(hi, lo, 1'b1, 0);
            pulse(-1, 0, rows[i].sec, !rows[i].sec);
            check_state(hi, lo, 1'b1, 0);
            pulse(-1, 0, !rows[i].sec, rows[i].sec);
            check_state(8'h00, 8'h00, 1'b0, 0);
        end
        $display("test sources done");
        host.write_reg(ADDR_EN_LOW, 8'h00);
        pulse(0, 0, 1'b0, 1'b0);
        check_state(8'h04, 8'h00, 1'b0, 0);
        pulse(-1, 0, 1'b0, 1'b1);
        check_state(8'h00, 8'h00, 1'b0, 0);
        $display("test gating done");
        host.write_reg(ADDR_PORT_SEL, 8'h12);
        host.write_reg(ADDR_EN_HIGH, 8'h07);
        pulse(2, 1, 1'b0, 1'b0);
        pulse(8, 1, 1'b0, 1'b0);
        check_state(8'h01, 8'h01, 1'b1, 1);
        check_reg(ADDR_EN_HIGH, 8'h07);
        host.write_reg(ADDR_PORT_SEL, 8'h02);
        pulse(-1, 0, 1'b1, 1'b0);
        check_state(8'h00, 8'h01, 1'b1, 1);
        check_reg(ADDR_EN_HIGH, 8'h00);
        host.write_reg(ADDR_PORT_SEL, 8'h12);
        pulse(-1, 0, 1'b1, 1'b0);
        check_state(8'h00, 8'h00, 1'b0, 1);
        $display("test ports done");
        host.write_reg(ADDR_EN_HIGH, 8'hff);
        check_reg(ADDR_EN_HIGH, 8'h07);
        host.write_reg(ADDR_EN_LOW, 8'hff);
        check_reg(ADDR_EN_LOW, 8'h77);
        host.write_reg(ADDR_ST_HIGH, 8'hff);
        check_reg(ADDR_ST_HIGH, 8'h00);
        check_reg(8'hdb, 8'h00);
        $display("test reserved done");
        pulse(1, 1, 1'b1, 1'b0);
        pulse(0, 1, 1'b0, 1'b0);
        check_state(8'h06, 8'h00, 1'b1, 1);
        pulse(-1, 0, 1'b1, 1'b0);
        check_state(8'h04, 8'h00, 1'b1, 1);
        pulse(-1, 0, 1'b0, 1'b1);
        check_state(8'h00, 8'h00, 1'b0, 1);
        $display("test clear order done");
        @(negedge clk_sys_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        check_reg(ADDR_PORT_SEL, SEL_RESET);
        check_reg(ADDR_EN_HIGH, REG_RESET);
        check_reg(ADDR_EN_LOW, REG_RESET);
        pulse(8, 0, 1'b0, 1'b0);
        check_state(8'h00, 8'h01, 1'b0, 0);
        $display("test second reset done");
        complete_run();
    end
endmodule

/* core/rpic_pkg.sv */
/*
 * Constants shared by the receive-port interrupt control block: register
 * addresses, field positions, writable masks, clear masks and reset values.
 * Assumes an 8-bit register address space reached by the host over I2C.
 */
package rpic_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
    localparam logic [7:0] ADDR_EN_HIGH  = 8'hd8;
    localparam logic [7:0] ADDR_EN_LOW   = 8'hd9;
    localparam logic [7:0] ADDR_ST_HIGH  = 8'hda;

    // Port select fields: write mask in [3:0], read port index in [5:4].
    localparam int         SEL_WR_LSB    = 0;
    localparam int         SEL_RD_LSB    = 4;
    localparam logic [7:0] SEL_MASK      = 8'h3f;
    localparam logic [7:0] SEL_RESET     = 8'h01;

    // Bit positions in the high registers.
    localparam int BIT_ENCODE_FAULT      = 2;
    localparam int BIT_ORDER_FAULT       = 1;
    localparam int BIT_CHECK_FAULT       = 0;

    // Bit positions in the low registers.
    localparam int BIT_LINE_LENGTH       = 6;
    localparam int BIT_LINE_TOTAL        = 5;
    localparam int BIT_RX_OVERFLOW       = 4;
    localparam int BIT_LINK_PARITY       = 2;
    localparam int BIT_PORT_VALID        = 1;
    localparam int BIT_LOCK_CHANGE       = 0;

    // Implemented bits; reserved bits read as zero.
    localparam logic [7:0] HIGH_MASK     = 8'h07;
    localparam logic [7:0] LOW_MASK      = 8'h77;

    // Status bits cleared by reads of the first and second port status.
    localparam logic [7:0] CLR_FIRST_HIGH  = 8'h03;
    localparam logic [7:0] CLR_SECOND_HIGH = 8'h04;
    localparam logic [7:0] CLR_FIRST_LOW   = 8'h07;
    localparam logic [7:0] CLR_SECOND_LOW  = 8'h70;

    // Reset value of all enable and status registers.
    localparam logic [7:0] REG_RESET     = 8'h00;

endpackage

/* core/rpic_port_slice.sv */
/*
 * One receive port's copy of the interrupt enable and status registers.
 * Assumes writes, status-read clears and events arrive as one-cycle pulses
 * already steered to this port by the parent.
 */
`timescale 1ns/1ps
module rpic_port_slice
(
    input  wire logic       clk_sys_i,      // System clock.
    input  wire logic       sys_rst_i,      // Asynchronous reset.
    input  wire logic       wr_en_high_i,   // Write high enable register.
    input  wire logic       wr_en_low_i,    // Write low enable register.
    input  wire logic [7:0] wdata_i,        // Write data.
    input  wire logic       clr_first_i,    // First port status was read.
    input  wire logic       clr_second_i,   // Second port status was read.
    input  wire logic [7:0] ev_high_i,      // Events, high status layout.
    input  wire logic [7:0] ev_low_i,       // Events, low status layout.
    output logic      [7:0] en_high_o,      // High enable register.
    output logic      [7:0] en_low_o,       // Low enable register.
    output logic      [7:0] st_high_o,      // High status register.
    output logic      [7:0] st_low_o,       // Low status register.
    output logic            pend_o          // Enabled status bit pending.
);
    import rpic_pkg::*;

    logic [7:0] clr_high;
    logic [7:0] clr_low;

    // Enable registers, reserved bits held at zero.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            en_high_o <= REG_RESET;
            en_low_o  <= REG_RESET;
        end
        else
        begin
            if (wr_en_high_i)
                en_high_o <= wdata_i & HIGH_MASK;
            if (wr_en_low_i)
                en_low_o <= wdata_i & LOW_MASK;
        end
    end

    // Which status bits a status register read clears.
    always_comb
    begin
        clr_high = (clr_first_i ? CLR_FIRST_HIGH : 8'h00)
                 | (clr_second_i ? CLR_SECOND_HIGH : 8'h00);
        clr_low  = (clr_first_i ? CLR_FIRST_LOW : 8'h00)
                 | (clr_second_i ? CLR_SECOND_LOW : 8'h00);
    end

    // Sticky status; an event in the clearing cycle keeps its bit set.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_high_o <= REG_RESET;
            st_low_o  <= REG_RESET;
        end
        else
        begin
            st_high_o <= (st_high_o & ~clr_high)
                       | (ev_high_i & HIGH_MASK);
            st_low_o  <= (st_low_o & ~clr_low)
                       | (ev_low_i & LOW_MASK);
        end
    end

    // A status bit raises the request only where its enable is set.
    assign pend_o = |(st_high_o & en_high_o)
                  | |(st_low_o & en_low_o);

endmodule

/* core/rpic_top.sv */
/*
 * Receive-port interrupt enable and status registers for a multi-port
 * serial deserializer hub, one copy per port, steered by port select.
 * Assumes an I2C target outside decodes host transfers into one-cycle
 * register read and write strobes, and that detection circuits and the
 * port status registers outside pulse their event and read inputs.
 */
`timescale 1ns/1ps
// Behaviour
// - Each port has its own enable/status copy; select at 0x4c steers access.
// - High enable bit 2 lets encoding errors raise the interrupt.
// - High enable bit 1 lets control channel sequence errors interrupt.
// - High enable bit 0 lets control channel frame CRC errors interrupt.
// - Low enable bit 6 lets video line length changes interrupt.
// - Low enable bit 5 lets line-per-frame count changes interrupt.
// - Low enable bit 4 lets receive buffer overflows interrupt.
// - Low enable bit 2 lets link parity errors interrupt.
// - Low enable bit 1 lets port-valid changes interrupt.
// - Low enable bit 0 lets lock status changes interrupt.
// - High status bit 2 sets on encoding error, clears on second status read.
// - High status bit 1 sets on sequence error, clears on first status read.
// - High status bit 0 sets on CRC error, clears on first status read.
// - Enable and high status registers reset to zero.
// - Line length, line count, overflow flags clear on second status read.
module rpic_top
#(
    parameter int NPORTS = 4                // Number of receive ports.
)
(
    input  wire logic              clk_sys_i,     // System clock.
    input  wire logic              sys_rst_i,     // Asynchronous reset.
    input  wire logic [7:0]        reg_addr_i,    // Register address.
    input  wire logic              reg_wr_i,      // Write strobe.
    input  wire logic              reg_rd_i,      // Read strobe.
    input  wire logic [7:0]        reg_wdata_i,   // Write data.
    output logic      [7:0]        reg_rdata_o,   // Read data, registered.
    input  wire logic              sts_first_rd_i,  // First status read.
    input  wire logic              sts_second_rd_i, // Second status read.
    input  wire logic [NPORTS-1:0] encode_fault_i,  // Encoding error.
    input  wire logic [NPORTS-1:0] order_fault_i,   // Ctrl sequence error.
    input  wire logic [NPORTS-1:0] check_fault_i,   // Ctrl CRC error.
    input  wire logic [NPORTS-1:0] line_length_i,   // Line length change.
    input  wire logic [NPORTS-1:0] line_total_i,    // Line count change.
    input  wire logic [NPORTS-1:0] rx_overflow_i,   // Buffer overflow.
    input  wire logic [NPORTS-1:0] link_parity_i,   // Parity error.
    input  wire logic [NPORTS-1:0] port_valid_i,    // Port valid change.
    input  wire logic [NPORTS-1:0] lock_change_i,   // Lock change.
    output logic [NPORTS*8-1:0]    st_low_o,      // Low status per port.
    output logic                   irq_o          // Interrupt request.
);
    import rpic_pkg::*;

    // Elaboration-time check on the port count.
    if (NPORTS < 1 || NPORTS > 4)
    begin : g_bad_nports
        $error("NPORTS must be between 1 and 4");
    end

    logic [7:0]        port_sel;
    logic [1:0]        rd_port;
    logic              rd_ok;
    logic [7:0]        en_high [NPORTS];
    logic [7:0]        en_low  [NPORTS];
    logic [7:0]        st_high [NPORTS];
    logic [7:0]        st_low  [NPORTS];
    logic [NPORTS-1:0] pend;
    logic [NPORTS-1:0] wr_high;
    logic [NPORTS-1:0] wr_low;
    logic [NPORTS-1:0] clr_first;
    logic [NPORTS-1:0] clr_second;

    // Read port index; an index past the last port reads as zero.
    assign rd_port = port_sel[SEL_RD_LSB +: 2];
    assign rd_ok   = (int'(rd_port) < NPORTS);

    // Port select register: write mask and read port index.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            port_sel <= SEL_RESET;
        else if (reg_wr_i && reg_addr_i == ADDR_PORT_SEL)
            port_sel <= reg_wdata_i & SEL_MASK;
    end

    // One register copy per port; writes go to every port in the mask.
    for (genvar p = 0; p < NPORTS; p++)
    begin : g_port
        assign wr_high[p] = reg_wr_i && reg_addr_i == ADDR_EN_HIGH
                          && port_sel[SEL_WR_LSB + p];
        assign wr_low[p]  = reg_wr_i && reg_addr_i == ADDR_EN_LOW
                          && port_sel[SEL_WR_LSB + p];
        assign clr_first[p]  = sts_first_rd_i && rd_port == 2'(p);
        assign clr_second[p] = sts_second_rd_i && rd_port == 2'(p);
        assign st_low_o[p*8 +: 8] = st_low[p];

        rpic_port_slice u_slice
        (
            .clk_sys_i    (clk_sys_i),
            .sys_rst_i    (sys_rst_i),
            .wr_en_high_i (wr_high[p]),
            .wr_en_low_i  (wr_low[p]),
            .wdata_i      (reg_wdata_i),
            .clr_first_i  (clr_first[p]),
            .clr_second_i (clr_second[p]),
            .ev_high_i    ({5'h00, encode_fault_i[p], order_fault_i[p],
                            check_fault_i[p]}),
            .ev_low_i     ({1'b0, line_length_i[p], line_total_i[p],
                            rx_overflow_i[p], 1'b0, link_parity_i[p],
                            port_valid_i[p], lock_change_i[p]}),
            .en_high_o    (en_high[p]),
            .en_low_o     (en_low[p]),
            .st_high_o    (st_high[p]),
            .st_low_o     (st_low[p]),
            .pend_o       (pend[p])
        );
    end

    // Read data is captured on the read strobe; unmapped reads give zero.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            if (reg_addr_i == ADDR_PORT_SEL)
                reg_rdata_o <= port_sel;
            else if (reg_addr_i == ADDR_EN_HIGH && rd_ok)
                reg_rdata_o <= en_high[rd_port];
            else if (reg_addr_i == ADDR_EN_LOW && rd_ok)
                reg_rdata_o <= en_low[rd_port];
            else if (reg_addr_i == ADDR_ST_HIGH && rd_ok)
                reg_rdata_o <= st_high[rd_port];
            else
                reg_rdata_o <= 8'h00;
        end
    end

    // The request combines every port and follows its cause by one cycle.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |pend;
    end

    // Helper: stays low until the first enable write after reset.
    logic en_written;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            en_written <= 1'b0;
        else if (|wr_high || |wr_low)
            en_written <= 1'b1;
    end

    // Any event on port 0 this cycle, used by the masked check.
    logic ev_any_p0;
    assign ev_any_p0 = encode_fault_i[0] | order_fault_i[0]
                     | check_fault_i[0] | line_length_i[0]
                     | line_total_i[0] | rx_overflow_i[0]
                     | link_parity_i[0] | port_valid_i[0]
                     | lock_change_i[0];

    // Port 0 is always present, so the checks watch its copy.
    sequence s_enc_armed;
        en_high[0][BIT_ENCODE_FAULT] && encode_fault_i[0]
        && !wr_high[0];
    endsequence

    sequence s_flag_then_irq;
        st_high[0][BIT_ENCODE_FAULT] ##1 irq_o;
    endsequence

    sequence s_second_read_p0;
        sts_second_rd_i && rd_port == 2'd0 && !line_length_i[0];
    endsequence

    a_enc_irq_raise: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_enc_armed |=> s_flag_then_irq)
        else $error("Enabled encoding error did not raise interrupt.");

    a_order_irq_raise: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        en_high[0][BIT_ORDER_FAULT] && order_fault_i[0]
        && !wr_high[0] |=> ##1 irq_o)
        else $error("Enabled sequence error did not raise interrupt.");

    a_check_irq_raise: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        en_high[0][BIT_CHECK_FAULT] && check_fault_i[0]
        && !wr_high[0] |=> ##1 irq_o)
        else $error("Enabled CRC error did not raise interrupt.");

    a_low_irq_raise: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        |(st_low[0] & en_low[0]) |=> irq_o)
        else $error("Enabled low status bit did not raise interrupt.");

    a_masked_quiet: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !en_written && !(|wr_high) && !(|wr_low) && ev_any_p0
        |=> ##1 !irq_o)
        else $error("Interrupt raised with all enables clear.");

    a_enc_flag_clear: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        sts_second_rd_i && rd_port == 2'd0 && !encode_fault_i[0]
        |=> !st_high[0][BIT_ENCODE_FAULT])
        else $error("Encoding flag not cleared by second status read.");

    a_order_flag_life: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        order_fault_i[0] |=> st_high[0][BIT_ORDER_FAULT]
        ##1 (st_high[0][BIT_ORDER_FAULT] || $past(clr_first[0])))
        else $error("Sequence flag not set or lost without a clear.");

    a_check_clear_win: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        clr_first[0] |=> st_high[0][BIT_CHECK_FAULT]
                         == $past(check_fault_i[0]))
        else $error("CRC flag wrong after first status read.");

    a_reset_enables: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !en_written |-> en_high[0] == REG_RESET && en_low[0] == REG_RESET)
        else $error("Enable register left its reset value unwritten.");

    a_low_clear_second: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        s_second_read_p0 |=> !st_low[0][BIT_LINE_LENGTH])
        else $error("Line length flag not cleared by second read.");

    a_irq_has_cause: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        irq_o |-> $past(pend) != {NPORTS{1'b0}})
        else $error("Interrupt without an enabled pending status.");

    a_sel_write_route: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == ADDR_EN_HIGH
        && !port_sel[SEL_WR_LSB] |=> $stable(en_high[0]))
        else $error("Write reached a port outside the write mask.");

    a_sel_read_route: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == ADDR_ST_HIGH && rd_port == 2'd0
        |=> reg_rdata_o == $past(st_high[0]))
        else $error("Status read did not return the selected port.");

    a_length_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        line_length_i[0] |=> st_low[0][BIT_LINE_LENGTH])
        else $error("Line length flag not set by its event.");

    a_total_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        line_total_i[0] |=> st_low[0][BIT_LINE_TOTAL])
        else $error("Line count flag not set by its event.");

    a_overflow_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        rx_overflow_i[0] |=> st_low[0][BIT_RX_OVERFLOW])
        else $error("Overflow flag not set by its event.");

    a_parity_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        link_parity_i[0] |=> st_low[0][BIT_LINK_PARITY])
        else $error("Parity flag not set by its event.");

    a_valid_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        port_valid_i[0] |=> st_low[0][BIT_PORT_VALID])
        else $error("Port valid flag not set by its event.");

    a_lock_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        lock_change_i[0] |=> st_low[0][BIT_LOCK_CHANGE])
        else $error("Lock flag not set by its event.");

    a_low_clear_first: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        clr_first[0] && !link_parity_i[0] && !port_valid_i[0]
        && !lock_change_i[0] |=> (st_low[0] & CLR_FIRST_LOW) == 8'h00)
        else $error("Low flags not cleared by first status read.");

    a_rdata_holds: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("Read data changed without a read strobe.");

    a_high_irq_raise: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        |(st_high[0] & en_high[0]) |=> irq_o)
        else $error("Enabled high status bit did not raise interrupt.");

    a_reserved_zero: assert property (
        @(posedge clk_sys_i) disable iff (sys_rst_i)
        (en_high[0] & ~HIGH_MASK) == 8'h00
        && (st_low[0] & ~LOW_MASK) == 8'h00)
        else $error("Reserved enable or status bit set.");

endmodule
